// File: rtl/sas_sequencer.sv
// Scan sequencer: channel stepping, gains, buffer writes, bursts, flags.
// Function
// - Convert channels in sequence, blocks of 16 to 64, into the data buffer.
// - Host can read the data buffer at all times, even during scanning.
// - Programmable gain uses per-channel gain buffer entry, else fixed jumper gain.
// - Gain buffer codes are unity, ten and one hundred only; FIXED_GAIN code 3 passes to PGA_GAIN unchecked.
// - Reset enters continuous scanning with a 64-channel block.
// - Reset with automatic gain sets every gain entry to unity.
// - After reset software may change mode, block size, buffer size, gains.
// - Block size is 16, 32, 48 or 64 channels.
// - Buffer size is 16 to 1024 words in six power-of-two steps.
// - Interval timer starts bursts repeatedly or once, up to 536 seconds.
// - Each burst takes a programmed count of 16 to 1024 samples.
// - Data ready flag at end of scan, optionally also at middle.
// - Interrupt request raised in the same cycle as the data ready flag.
// - Separate interrupt after a programmed count of samples.
// - Channel zero at lowest block address, higher channels ascending.
// - Data ready set at top or middle address; readable as status.
// - Host access colliding with converter write is stretched about 250 ns.
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer (
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   SYS_RST,
    // Configuration
    input  wire logic [1:0]             MODE,
    input  wire logic [1:0]             BLOCK_SEL,
    input  wire logic [2:0]             BUF_SEL,
    input  wire logic                   AUTO_GAIN,
    input  wire logic [1:0]             FIXED_GAIN,
    input  wire logic                   MID_FLAG_EN,
    input  wire logic                   IRQ_EN,
    input  wire logic                   REPEAT_EN,
    input  wire logic [31:0]            INTERVAL,
    input  wire logic [10:0]            BURST_LEN,
    input  wire logic [10:0]            COUNT_LEN,
    input  wire logic [5:0]             SINGLE_CHAN,
    input  wire logic                   START,
    input  wire logic                   TRIG_IN,
    input  wire logic                   FLAG_CLR,
    // Gain loading
    input  wire logic                   GAIN_WE,
    input  wire logic [5:0]             GAIN_ADDR,
    input  wire logic [1:0]             GAIN_DATA,
    // Converter
    input  wire logic [15:0]            ADC_DATA,
    output var  logic [5:0]             MUX_CHAN,
    output var  logic [1:0]             PGA_GAIN,
    output var  logic                   CONV_GO,
    // Host buffer access
    input  wire logic                   HOST_REQ,
    input  wire logic                   HOST_WE,
    input  wire logic [10:0]            HOST_ADDR,
    input  wire logic [15:0]            HOST_WDATA,
    output var  logic [15:0]            HOST_RDATA,
    output var  logic                   HOST_ACK,
    // Status
    output var  logic                   DATA_READY,
    output var  logic                   IRQ_READY,
    output var  logic                   IRQ_COUNT,
    output var  logic [10:0]            WR_PTR
);
    localparam int unsigned TIMER_W = 32;

    // Trigger synchroniser; the rising edge is taken from the second and third stages.
    logic trig_s1_reg, trig_s2_reg, trig_s3_reg;
    always_ff @(posedge CLK) begin
        trig_s1_reg <= TRIG_IN;
        trig_s2_reg <= trig_s1_reg;
        trig_s3_reg <= trig_s2_reg;
    end
    logic trig_rise;
    assign trig_rise = trig_s2_reg & ~trig_s3_reg;

    // Gain buffer.
    logic [1:0] gain_mem [0:63];
    logic [5:0] gi_reg, gi_next;
    logic       ginit_reg, ginit_next;
    always_comb begin
        gi_next = gi_reg;
        ginit_next = ginit_reg;
        if (ginit_reg) begin
            gi_next = gi_reg + 6'h01;
            if (gi_reg == sas_pkg::CHAN_MAX) ginit_next = 1'b0;
        end
    end
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            gi_reg    <= 6'h00;
            ginit_reg <= 1'b1;
        end else begin
            gi_reg    <= gi_next;
            ginit_reg <= ginit_next;
        end
    end
    always_ff @(posedge CLK) begin
        if (ginit_reg && AUTO_GAIN) begin
            gain_mem[gi_reg] <= sas_pkg::GAIN_X1;
        end else if (GAIN_WE && GAIN_DATA <= sas_pkg::GAIN_X100) begin
            gain_mem[GAIN_ADDR] <= GAIN_DATA;
        end
    end

    // Fractional divider: 8 MHz ticks on average, so a full 32-bit interval still reaches 536 s.
    logic [6:0]  div_reg, div_next;
    logic [TIMER_W-1:0] tmr_reg, tmr_next;
    logic        armed_reg, armed_next;
    logic        tick;
    assign tick = (div_reg >= 7'(sas_pkg::TICK_MOD - sas_pkg::TICK_STEP));

    // Scan engine.
    sas_pkg::sas_state_t st_reg, st_next;
    logic [5:0]  chan_reg, chan_next;
    logic [10:0] ptr_reg, ptr_next;
    logic [10:0] burst_reg, burst_next;
    logic [10:0] cnt_reg, cnt_next;
    logic [10:0] cyc_reg, cyc_next;
    logic        run_reg, run_next;
    logic        dr_reg, dr_next, irq_r_reg, irq_r_next, irq_c_reg, irq_c_next;
    logic [15:0] sample_reg, sample_next;
    logic        a_we;
    logic [4:0]  stretch_reg, stretch_next;
    logic        ack_reg, ack_next, hold_reg, hold_next;
    logic [10:0] buf_words, buf_top;
    logic [5:0]  blk_top;
    logic [1:0]  gain_now;
    logic        burst_mode, burst_start, top_hit, mid_hit;

    assign buf_words  = 11'h010 << BUF_SEL;
    assign buf_top    = buf_words - 11'h001;
    assign blk_top    = {BLOCK_SEL, 4'hf};
    assign gain_now   = AUTO_GAIN ? gain_mem[chan_reg] : FIXED_GAIN;
    assign burst_mode = (MODE == sas_pkg::MODE_TIMED) || (MODE == sas_pkg::MODE_TRIG);
    assign top_hit    = (ptr_reg == buf_top);
    assign mid_hit    = (ptr_reg == (buf_words >> 1) - 11'h001);
    assign a_we       = (st_reg == sas_pkg::ST_WRITE) && !hold_reg;

    always_comb begin
        div_next   = div_reg + 7'(sas_pkg::TICK_STEP);
        if (tick) div_next = div_reg - 7'(sas_pkg::TICK_MOD - sas_pkg::TICK_STEP);
        tmr_next   = tmr_reg;
        armed_next = armed_reg;
        burst_start = 1'b0;
        if (MODE == sas_pkg::MODE_TIMED && armed_reg && tick) begin
            if (tmr_reg == 32'h0) begin
                burst_start = 1'b1;
                tmr_next    = INTERVAL;
                armed_next  = REPEAT_EN;
            end else begin
                tmr_next = tmr_reg - 32'h1;
            end
        end
        if (START) begin
            armed_next = 1'b1;
            tmr_next   = INTERVAL;
        end
        if (MODE == sas_pkg::MODE_TRIG && trig_rise) burst_start = 1'b1;
    end

    always_comb begin
        st_next     = st_reg;
        chan_next   = chan_reg;
        ptr_next    = ptr_reg;
        burst_next  = burst_reg;
        cnt_next    = cnt_reg;
        cyc_next    = cyc_reg;
        run_next    = run_reg;
        sample_next = sample_reg;
        dr_next     = dr_reg;
        irq_r_next  = 1'b0;
        irq_c_next  = 1'b0;
        if (FLAG_CLR) dr_next = 1'b0;
        if (burst_mode && burst_start && !run_reg) begin
            run_next   = 1'b1;
            burst_next = BURST_LEN;
        end
        if (MODE == sas_pkg::MODE_SINGLE && START) run_next = 1'b1;
        case (st_reg)
            sas_pkg::ST_IDLE: begin
                if (MODE == sas_pkg::MODE_CONT || run_reg) begin
                    st_next  = sas_pkg::ST_CONV;
                    cyc_next = 11'(sas_pkg::CONV_CYC - 1);
                end
            end
            sas_pkg::ST_CONV: begin
                if (cyc_reg == 11'h000) begin
                    st_next     = sas_pkg::ST_WRITE;
                    sample_next = ADC_DATA;
                end else begin
                    cyc_next = cyc_reg - 11'h001;
                end
            end
            sas_pkg::ST_WRITE: begin
                if (!hold_reg) begin
                    st_next  = sas_pkg::ST_IDLE;
                    chan_next = (chan_reg == blk_top) ? 6'h00 : chan_reg + 6'h01;
                    ptr_next  = top_hit ? 11'h000 : ptr_reg + 11'h001;
                    if (top_hit || (MID_FLAG_EN && mid_hit)) begin
                        dr_next    = 1'b1;
                        irq_r_next = IRQ_EN;
                    end
                    cnt_next = cnt_reg + 11'h001;
                    if (cnt_reg + 11'h001 == COUNT_LEN) begin
                        cnt_next   = 11'h000;
                        irq_c_next = IRQ_EN;
                    end
                    if (MODE == sas_pkg::MODE_SINGLE) run_next = 1'b0;
                    if (burst_mode) begin
                        burst_next = burst_reg - 11'h001;
                        if (burst_reg == 11'h001) run_next = 1'b0;
                    end
                end
            end
            default: st_next = sas_pkg::ST_IDLE;
        endcase
        if (MODE == sas_pkg::MODE_SINGLE) chan_next = SINGLE_CHAN;
    end

    // Host port: a request meeting a converter write waits STRETCH_CYC cycles.
    always_comb begin
        ack_next     = 1'b0;
        hold_next    = 1'b0;
        stretch_next = stretch_reg;
        if (HOST_REQ && !ack_reg) begin
            if (stretch_reg != 5'h00) begin
                stretch_next = stretch_reg - 5'h01;
                ack_next     = (stretch_reg == 5'h01);
                // A stretched write lands with its acknowledge, once the converter has let go.
                hold_next    = HOST_WE && (stretch_reg == 5'h01);
            end else if (st_reg == sas_pkg::ST_WRITE) begin
                stretch_next = 5'(sas_pkg::STRETCH_CYC);
            end else begin
                ack_next  = 1'b1;
                hold_next = HOST_WE;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st_reg      <= sas_pkg::ST_IDLE;
            chan_reg    <= 6'h00;
            ptr_reg     <= 11'h000;
            burst_reg   <= 11'h000;
            cnt_reg     <= 11'h000;
            cyc_reg     <= 11'h000;
            run_reg     <= 1'b0;
            sample_reg  <= 16'h0000;
            dr_reg      <= 1'b0;
            irq_r_reg   <= 1'b0;
            irq_c_reg   <= 1'b0;
            div_reg     <= 7'h00;
            tmr_reg     <= 32'h0;
            armed_reg   <= 1'b0;
            stretch_reg <= 5'h00;
            ack_reg     <= 1'b0;
            hold_reg    <= 1'b0;
        end else begin
            st_reg      <= st_next;
            chan_reg    <= chan_next;
            ptr_reg     <= ptr_next;
            burst_reg   <= burst_next;
            cnt_reg     <= cnt_next;
            cyc_reg     <= cyc_next;
            run_reg     <= run_next;
            sample_reg  <= sample_next;
            dr_reg      <= dr_next;
            irq_r_reg   <= irq_r_next;
            irq_c_reg   <= irq_c_next;
            div_reg     <= div_next;
            tmr_reg     <= tmr_next;
            armed_reg   <= armed_next;
            stretch_reg <= stretch_next;
            ack_reg     <= ack_next;
            hold_reg    <= hold_next;
        end
    end

    // Converter write and host access share the buffer; a host write already held delays the converter write.
    sas_dpram u_ram (
        .clk     (CLK),
        .a_we    (a_we),
        .a_addr  (ptr_reg),
        .a_wdata (sample_reg),
        .b_we    (hold_reg),
        .b_addr  (HOST_ADDR),
        .b_wdata (HOST_WDATA),
        .b_rdata (HOST_RDATA)
    );

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            MUX_CHAN <= 6'h00;
            PGA_GAIN <= sas_pkg::GAIN_X1;
            CONV_GO  <= 1'b0;
        end else begin
            MUX_CHAN <= chan_reg;
            PGA_GAIN <= gain_now;
            CONV_GO  <= (st_next == sas_pkg::ST_CONV) && (st_reg == sas_pkg::ST_IDLE);
        end
    end

    assign HOST_ACK   = ack_reg;
    assign DATA_READY = dr_reg;
    assign IRQ_READY  = irq_r_reg;
    assign IRQ_COUNT  = irq_c_reg;
    assign WR_PTR     = ptr_reg;

    AST_IRQ_WITH_FLAG: assert property (@(posedge CLK) disable iff (SYS_RST)
        IRQ_READY |-> DATA_READY) else $error("ready irq without flag");
    AST_PTR_WRAP: assert property (@(posedge CLK) disable iff (SYS_RST)
        (a_we && ptr_reg == buf_top && $stable(BUF_SEL)) |=> WR_PTR == 11'h000)
        else $error("pointer did not wrap");
    AST_PTR_STEP: assert property (@(posedge CLK) disable iff (SYS_RST)
        (a_we && ptr_reg != buf_top && $stable(BUF_SEL)) |=> WR_PTR == $past(ptr_reg) + 11'h001)
        else $error("pointer did not advance");
    AST_FLAG_TOP: assert property (@(posedge CLK) disable iff (SYS_RST)
        (a_we && top_hit) |=> DATA_READY) else $error("flag missed at top");
    AST_GAIN_LEGAL: assert property (@(posedge CLK) disable iff (SYS_RST)
        PGA_GAIN != 2'h3) else $error("illegal gain code");
    AST_CONV_TIME: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(CONV_GO) |-> !a_we [*8]) else $error("write too soon after start");
    AST_STRETCH: assert property (@(posedge CLK) disable iff (SYS_RST)
        (HOST_REQ && !HOST_ACK && st_reg == sas_pkg::ST_WRITE && stretch_reg == 5'h00)
        |-> ##[1:40] HOST_ACK) else $error("host access not completed");
    AST_RESET_CONT: assert property (@(posedge CLK)
        $past(SYS_RST) |-> st_reg == sas_pkg::ST_IDLE && WR_PTR == 11'h000)
        else $error("bad reset state");
endmodule : sas_sequencer
`default_nettype wire

// File: common/sas_pkg.sv
// Shared constants and types for the scanning converter sequencer.
package sas_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned CONV_NS         = 17_000;
    localparam int unsigned CONV_CYC        = (CONV_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned STRETCH_NS      = 250;
    localparam int unsigned STRETCH_CYC     = (STRETCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned TICK_HZ         = 8_000_000;
    localparam int unsigned TICK_STEP       = TICK_HZ / 1_000_000;
    localparam int unsigned TICK_MOD        = CLK_HZ / 1_000_000;
    localparam int unsigned INTERVAL_MAX_S  = 536;
    localparam int unsigned AW              = 11;
    localparam int unsigned DW              = 16;
    localparam logic [1:0]  GAIN_X1         = 2'h0;
    localparam logic [1:0]  GAIN_X10        = 2'h1;
    localparam logic [1:0]  GAIN_X100       = 2'h2;
    localparam logic [1:0]  BLK_RST         = 2'h3;
    localparam logic [2:0]  BUF_RST         = 3'h6;
    localparam logic [5:0]  CHAN_MAX        = 6'h3f;
    typedef enum logic [1:0] {MODE_CONT, MODE_TIMED, MODE_TRIG, MODE_SINGLE} sas_mode_t;
    typedef enum {ST_IDLE, ST_CONV, ST_WRITE} sas_state_t;
endpackage : sas_pkg

// File: rtl/sas_dpram.sv
// Dual-port data buffer: converter write port and host read/write port.
`timescale 1ns/1ps
`default_nettype none
module sas_dpram (
    // Clock
    input  wire logic                      clk,
    // Converter port
    input  wire logic                      a_we,
    input  wire logic [sas_pkg::AW-1:0]    a_addr,
    input  wire logic [sas_pkg::DW-1:0]    a_wdata,
    // Host port
    input  wire logic                      b_we,
    input  wire logic [sas_pkg::AW-1:0]    b_addr,
    input  wire logic [sas_pkg::DW-1:0]    b_wdata,
    output var  logic [sas_pkg::DW-1:0]    b_rdata
);
    logic [sas_pkg::DW-1:0] mem [0:(1<<sas_pkg::AW)-1];

    // Writes come from one port at a time; the sequencer arbitrates.
    always_ff @(posedge clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end else if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        b_rdata <= mem[b_addr];
    end
endmodule : sas_dpram
`default_nettype wire

// File: dv/sas_adc_model.sv
// Behavioural converter front end for the scan sequencer bench.
`timescale 1ns/1ps
`default_nettype none
module sas_adc_model (
    // Converter controls
    input  wire logic [5:0]  mux_chan,
    input  wire logic [1:0]  pga_gain,
    // Result
    output var  logic [15:0] adc_data
);
    // Channel and gain are folded into the code so a misrouted or misgained sample shows up in the buffer.
    always_comb begin
        adc_data = {pga_gain, 8'ha5, mux_chan};
    end
endmodule : sas_adc_model
`default_nettype wire

// File: dv/sas_sequencer_tb.sv
// Self-checking bench for the scan sequencer.
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer_tb;
    logic        clk        = 1'b0;
    logic        sys_rst    = 1'b1;
    logic [1:0]  mode       = 2'h0;
    logic [1:0]  block_sel  = sas_pkg::BLK_RST;
    logic [2:0]  buf_sel    = sas_pkg::BUF_RST;
    logic        auto_gain  = 1'b1;
    logic [1:0]  fixed_gain = sas_pkg::GAIN_X100;
    logic        rep_en     = 1'b0;
    logic [31:0] interval   = 32'h0;
    logic [10:0] burst_len  = 11'h10;
    logic [10:0] count_len  = 11'h5;
    logic [5:0]  single_ch  = 6'h0;
    logic        start      = 1'b0;
    logic        trig_in    = 1'b0;
    logic        flag_clr   = 1'b0;
    logic        gain_we    = 1'b0;
    logic [5:0]  gain_addr  = 6'h0;
    logic [1:0]  gain_data  = 2'h0;
    logic [15:0] adc_data;
    logic [5:0]  mux_chan;
    logic [1:0]  pga_gain;
    logic        conv_go;
    logic        host_req   = 1'b0;
    logic        host_we    = 1'b0;
    logic [10:0] host_addr  = 11'h0;
    logic [15:0] host_wdata = 16'h0;
    logic [15:0] host_rdata;
    logic        host_ack;
    logic        data_ready;
    logic        irq_ready;
    logic        irq_count;
    logic [10:0] wr_ptr;
    logic [1:0]  exp_gain [16];
    logic        dr_q       = 1'b0;
    int          num_errors = 0;
    int          total_checks = 0;
    int          irq_rd_n   = 0;
    int          irq_cnt_n  = 0;
    int          host_n     = 0;

    always #5 clk = ~clk;

    sas_sequencer u_dut (
        .CLK(clk), .SYS_RST(sys_rst), .MODE(mode), .BLOCK_SEL(block_sel), .BUF_SEL(buf_sel),
        .AUTO_GAIN(auto_gain), .FIXED_GAIN(fixed_gain), .MID_FLAG_EN(1'b1), .IRQ_EN(1'b1),
        .REPEAT_EN(rep_en), .INTERVAL(interval), .BURST_LEN(burst_len), .COUNT_LEN(count_len),
        .SINGLE_CHAN(single_ch), .START(start), .TRIG_IN(trig_in), .FLAG_CLR(flag_clr),
        .GAIN_WE(gain_we), .GAIN_ADDR(gain_addr), .GAIN_DATA(gain_data), .ADC_DATA(adc_data),
        .MUX_CHAN(mux_chan), .PGA_GAIN(pga_gain), .CONV_GO(conv_go), .HOST_REQ(host_req),
        .HOST_WE(host_we), .HOST_ADDR(host_addr), .HOST_WDATA(host_wdata), .HOST_RDATA(host_rdata),
        .HOST_ACK(host_ack), .DATA_READY(data_ready), .IRQ_READY(irq_ready), .IRQ_COUNT(irq_count),
        .WR_PTR(wr_ptr)
    );

    sas_adc_model u_adc (.mux_chan(mux_chan), .pga_gain(pga_gain), .adc_data(adc_data));

    // The interrupt only counts when it lands in the very cycle the flag rises.
    always @(posedge clk) begin
        dr_q <= data_ready;
        if (irq_ready === 1'b1 && data_ready === 1'b1 && dr_q === 1'b0) irq_rd_n++;
        if (irq_count === 1'b1) irq_cnt_n++;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic host(input logic we, input logic [10:0] addr, input logic [15:0] wd, output logic [15:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        host_req = 1'b1;
        host_we = we;
        host_addr = addr;
        host_wdata = wd;
        do begin
            @(posedge clk);
            n++;
        end while (host_ack !== 1'b1 && n < 100);
        rd = host_rdata;
        host_n = n;
        if (n >= 100) chk("host_ack", 16'h1, 16'h0);
        #1;
        host_req = 1'b0;
        @(posedge clk);
    endtask : host

    task automatic gain_wr(input logic [5:0] a, input logic [1:0] d);
        @(posedge clk);
        #1;
        gain_we = 1'b1;
        gain_addr = a;
        gain_data = d;
        @(posedge clk);
        #1;
        gain_we = 1'b0;
    endtask : gain_wr

    task automatic wait_go();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (conv_go !== 1'b1 && n < 2500);
        if (n >= 2500) chk("conv_go", 16'h1, 16'h0);
    endtask : wait_go

    task automatic count_go(input int cycles, output int n);
        n = 0;
        repeat (cycles) begin
            @(posedge clk);
            if (conv_go === 1'b1) n++;
        end
    endtask : count_go

    task automatic pulse_start();
        #1;
        start = 1'b1;
        @(posedge clk);
        #1;
        start = 1'b0;
    endtask : pulse_start

    task automatic end_of_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // Sized for one scan, one collision, two bursts and one single conversion with margin.
    initial begin
        #960000;
        num_errors++;
        end_of_test();
    end

    initial begin
        logic [15:0] rd;
        int n;
        foreach (exp_gain[k]) exp_gain[k] = sas_pkg::GAIN_X1;
        exp_gain[1] = sas_pkg::GAIN_X10;
        exp_gain[2] = sas_pkg::GAIN_X100;
        repeat (20) @(posedge clk);
        chk("ready_rst", 16'h0, 16'(data_ready));
        #1;
        sys_rst = 1'b0;
        block_sel = 2'h0;
        buf_sel = 3'h0;
        fork
            begin
                for (int i = 0; i <= 16; i++) begin
                    wait_go();
                    chk("chan", 16'(i % 16), 16'(mux_chan));
                    chk("gain", 16'(exp_gain[i % 16]), 16'(pga_gain));
                    chk("wptr", 16'(i % 16), 16'(wr_ptr));
                    chk("ready", 16'(i == 8 || i == 16), 16'(data_ready));
                    if (i == 8) begin
                        #1;
                        flag_clr = 1'b1;
                        @(posedge clk);
                        #1;
                        flag_clr = 1'b0;
                    end
                end
            end
            begin
                // Loaded after the reset preload so the unity fill cannot overwrite them.
                repeat (80) @(posedge clk);
                gain_wr(6'h01, sas_pkg::GAIN_X10);
                gain_wr(6'h02, sas_pkg::GAIN_X100);
                gain_wr(6'h03, 2'h3);
            end
        join
        chk("irq_ready", 16'h2, 16'(irq_rd_n));
        chk("irq_count", 16'h3, 16'(irq_cnt_n));
        for (int a = 0; a < 16; a++) begin
            host(1'b0, 11'(a), 16'h0, rd);
            chk("buf", {exp_gain[a], 8'ha5, 6'(a)}, rd);
        end
        host(1'b1, 11'h7ff, 16'hbeef, rd);
        host(1'b0, 11'h7ff, 16'h0, rd);
        chk("scratch", 16'hbeef, rd);
        chk("ack_cycles", 16'h2, 16'(host_n));
        // Start a host write on the very edge at which the converter owns the buffer.
        wait_go();
        repeat (sas_pkg::CONV_CYC - 2) @(posedge clk);
        host(1'b1, 11'h7fe, 16'hcafe, rd);
        chk("stretch_cycles", 16'(sas_pkg::STRETCH_CYC + 2), 16'(host_n));
        host(1'b0, 11'h7fe, 16'h0, rd);
        chk("stretch_data", 16'hcafe, rd);
        #1;
        mode = 2'h2;
        burst_len = 11'h10;
        repeat (2000) @(posedge clk);
        #1;
        trig_in = 1'b1;
        count_go(16 * 1702 + 600, n);
        chk("trig_burst", 16'h10, 16'(n));
        #1;
        trig_in = 1'b0;
        mode = 2'h1;
        interval = 32'h3;
        rep_en = 1'b0;
        @(posedge clk);
        pulse_start();
        count_go(16 * 1702 + 600, n);
        chk("burst", 16'h10, 16'(n));
        #1;
        mode = 2'h3;
        single_ch = 6'h2a;
        auto_gain = 1'b0;
        fixed_gain = sas_pkg::GAIN_X10;
        @(posedge clk);
        pulse_start();
        wait_go();
        chk("single_chan", 16'h2a, 16'(mux_chan));
        chk("fixed_gain", 16'(sas_pkg::GAIN_X10), 16'(pga_gain));
        count_go(2000, n);
        chk("single_count", 16'h0, 16'(n));
        end_of_test();
    end
endmodule : sas_sequencer_tb
`default_nettype wire
